// ===== hdl/ucrm_channel.sv
// Register set of one serial channel as seen by the host on the parallel bus.
// What this block does
// (R01) Each channel has its own byte registers, picked by 3-bit address and channel select.
// (R02) Offset 0, divisor bit clear: read gives receive byte, write loads transmit byte.
// (R03) Divisor bit set: offsets 0 and 1 access divisor low and high bytes.
// (R04) Offset 1 is interrupt mask: bits 0-3 enable four sources, upper bits zero.
// (R05) Offset 2 read: bits 7,6 FIFOs enabled, 5,4 zero, 3-0 source code.
// (R06) Offset 2 write: FIFO enable, receive reset, transmit reset, DMA mode, trigger select.
// (R07) Offset 3 is read/write line format, bit 7 selecting the divisor bytes.
// (R08) Offset 4 modem control: loopback, interrupt output enable, spare, RTS, DTR; upper zero.
// (R09) Offset 5 returns line status: global error, empties, break, framing, parity, overrun, ready.
// (R10) Offset 6 returns modem input states in 7-4 and their change flags in 3-0.
// (R11) Offset 7 is an eight-bit scratch byte with no side effect.
// (R12) Mask gates the four sources; the highest-priority enabled one is reported in interrupt status.
// (R13) FIFO mode: receive interrupt raised at trigger fill, dropped below it.
// (R14) Receive-level code and interrupt output clear together when fill drops below trigger.
// (R15) Data ready sets when a byte enters the receive FIFO, clears when it empties.
// (R16) FIFO control bits other than enable take effect only when bit 0 is written one.
// (R17) Trigger codes 00, 01, 10, 11 give 1, 4, 8, 14 characters.
// (R18) Status bit 0 is one with nothing pending, and at reset.
// (R19) Reserved bits ignore writes and read zero.
module ucrm_channel
  import ucrm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic chan_sel,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data,
  input wire logic rx_char_valid,
  input wire logic [DATA_W-1:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_framing_err,
  input wire logic rx_break,
  input wire logic rx_timeout,
  output logic tx_char_valid,
  output logic [DATA_W-1:0] tx_holding,
  input wire logic tx_take,
  input wire logic tx_shifter_empty,
  input wire logic clear_to_send_in,
  input wire logic data_set_ready_in,
  input wire logic ring_indicator_in,
  input wire logic carrier_detect_in,
  output logic [15:0] divisor,
  output logic [7:0] line_format,
  output logic fifo_dma_mode,
  output logic loopback_en,
  output logic irq_output_enable,
  output logic spare_output,
  output logic rts_out,
  output logic dtr_out,
  output logic irq
);
  typedef enum logic [2:0] {
    UCRM_TX_EMPTY = 3'b001,
    UCRM_TX_HELD = 3'b010,
    UCRM_TX_FLUSH = 3'b100
  } ucrm_tx_state_type;

  logic [7:0] interrupt_mask_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] line_format_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] scratch_reg;
  logic [7:0] div_lo_reg;
  logic [7:0] div_hi_reg;
  logic [7:0] rd_data_reg;
  logic [DATA_W-1:0] tx_holding_reg;
  ucrm_tx_state_type tx_state_reg;
  ucrm_tx_state_type tx_state_next;
  logic overrun_reg;
  logic tx_irq_reg;
  logic [3:0] modem_prev_reg;
  logic [3:0] modem_delta_reg;
  logic rx_flush_reg;
  logic [10:0] fifo_head;
  logic [LEVEL_W-1:0] fifo_level;
  logic fifo_full;
  logic [7:0] interrupt_status;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [3:0] modem_in;
  logic [LEVEL_W-1:0] trigger;
  logic fifo_on;
  logic div_sel;
  logic rd_hit;
  logic wr_hit;
  logic rd_rx_data;
  logic rd_line_stat;
  logic rd_modem_stat;
  logic rd_int_stat;
  logic wr_tx_data;
  logic wr_fcr;
  logic rx_push;
  logic data_ready;
  logic line_err;
  logic global_err;
  logic src_line;
  logic src_rx;
  logic src_tx;
  logic src_modem;
  logic src_timeout;
  logic [3:0] src_code;
  logic tx_going_empty;
  logic tx_irq_arm;

  assign fifo_on = fifo_control_reg[FCR_ENABLE_BIT];
  assign div_sel = line_format_reg[FMT_DIV_BIT];
  assign rd_hit = chan_sel && rd_strobe; // [R01]
  assign wr_hit = chan_sel && wr_strobe; // [R01]
  assign rd_rx_data = rd_hit && (reg_addr == OFS_DATA) && !div_sel;
  assign rd_line_stat = rd_hit && (reg_addr == OFS_LINE_STAT);
  assign rd_modem_stat = rd_hit && (reg_addr == OFS_MODEM_STAT);
  assign rd_int_stat = rd_hit && (reg_addr == OFS_STATUS);
  assign wr_tx_data = wr_hit && (reg_addr == OFS_DATA) && !div_sel; // [R02]
  assign wr_fcr = wr_hit && (reg_addr == OFS_STATUS);
  // Unmasking the transmit source while nothing waits raises it at once.
  assign tx_irq_arm = wr_hit && (reg_addr == OFS_MASK) && !div_sel && wr_data[MASK_TX_BIT] &&
    !interrupt_mask_reg[MASK_TX_BIT];

  // Without FIFO mode the receive path keeps only one byte, like a bare holding register.
  assign rx_push = rx_char_valid && (fifo_on ? !fifo_full : (fifo_level == '0));

  ucrm_rx_fifo u_rx_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .flush(rx_flush_reg),
    .push(rx_push),
    .push_data({rx_break, rx_framing_err, rx_parity_err, rx_char}),
    .pop(rd_rx_data),
    .head_data(fifo_head),
    .level(fifo_level),
    .full(fifo_full)
  );

  always_comb begin
    unique case (fifo_control_reg[FCR_TRIG_LO +: 2]) // [R17]
      2'b00: trigger = TRIG_1;
      2'b01: trigger = TRIG_4;
      2'b10: trigger = TRIG_8;
      2'b11: trigger = TRIG_14;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_mask_reg <= RST_MASK;
      line_format_reg <= RST_FORMAT;
      modem_control_reg <= RST_MCTL;
      scratch_reg <= RST_SCRATCH;
      div_lo_reg <= RST_DIV_LO;
      div_hi_reg <= RST_DIV_HI;
    end else if (clk_en && wr_hit) begin
      unique case (reg_addr)
        OFS_DATA: begin
          if (div_sel) begin
            div_lo_reg <= wr_data; // [R03]
          end
        end
        OFS_MASK: begin
          if (div_sel) begin
            div_hi_reg <= wr_data; // [R03]
          end else begin
            interrupt_mask_reg <= wr_data & MASK_IMPL; // [R04] [R19]
          end
        end
        OFS_FORMAT: line_format_reg <= wr_data; // [R07]
        OFS_MODEM_CTL: modem_control_reg <= wr_data & MCTL_IMPL; // [R08] [R19]
        OFS_SCRATCH: scratch_reg <= wr_data; // [R11]
        default: begin
        end
      endcase
    end
  end

  // The reset bits self-clear; they live only in the one-cycle flush pulses.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_control_reg <= RST_FCR;
      rx_flush_reg <= 1'b0;
    end else if (clk_en) begin
      rx_flush_reg <= 1'b0;
      if (wr_fcr) begin
        if (wr_data[FCR_ENABLE_BIT]) begin
          fifo_control_reg <= wr_data & FCR_IMPL & FCR_KEEP; // [R06] [R16] [R19]
          rx_flush_reg <= wr_data[FCR_RX_RESET_BIT]; // [R06]
        end else begin
          fifo_control_reg <= RST_FCR; // [R16]
          rx_flush_reg <= fifo_on;
        end
      end
    end
  end

  // Transmit holding byte: taken by the shifter, or dropped by a transmit reset.
  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      UCRM_TX_EMPTY: begin
        if (wr_tx_data) begin
          tx_state_next = UCRM_TX_HELD;
        end
      end
      UCRM_TX_HELD: begin
        if (wr_fcr && wr_data[FCR_ENABLE_BIT] && wr_data[FCR_TX_RESET_BIT]) begin
          tx_state_next = UCRM_TX_FLUSH;
        end else if (tx_take) begin
          tx_state_next = UCRM_TX_EMPTY;
        end
      end
      // A byte written right behind a transmit reset must not be lost.
      UCRM_TX_FLUSH: begin
        if (wr_tx_data) begin
          tx_state_next = UCRM_TX_HELD;
        end else begin
          tx_state_next = UCRM_TX_EMPTY;
        end
      end
      default: tx_state_next = UCRM_TX_EMPTY;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg <= UCRM_TX_EMPTY;
      tx_holding_reg <= '0;
    end else if (clk_en) begin
      tx_state_reg <= tx_state_next;
      if (wr_tx_data) begin
        tx_holding_reg <= wr_data; // [R02]
      end
    end
  end

  assign tx_going_empty = (tx_state_reg != UCRM_TX_EMPTY) && (tx_state_next == UCRM_TX_EMPTY);

  // Transmit-empty interrupt: set on becoming empty, cleared by status read or a new byte.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_irq_reg <= 1'b0;
    end else if (clk_en) begin
      if (tx_going_empty) begin
        tx_irq_reg <= 1'b1;
      end else if (tx_irq_arm) begin
        tx_irq_reg <= (tx_state_reg == UCRM_TX_EMPTY);
      end else if (wr_tx_data || (rd_int_stat && src_code == SRC_TX_EMPTY)) begin
        tx_irq_reg <= 1'b0;
      end
    end
  end

  // Overrun flag: a newly lost byte wins over the clearing status read.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_reg <= 1'b0;
    end else if (clk_en) begin
      if (rx_char_valid && !rx_push) begin
        overrun_reg <= 1'b1;
      end else if (rd_line_stat) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // Modem change flags: a new change wins over the clearing status read.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      modem_delta_reg <= '0;
      modem_prev_reg <= '0;
    end else if (clk_en) begin
      modem_prev_reg <= modem_in;
      modem_delta_reg <= (rd_modem_stat ? 4'h0 : modem_delta_reg) | (modem_in ^ modem_prev_reg);
    end
  end

  // Loopback isolates the modem inputs; they then read as idle.
  assign modem_in = loopback_en ? 4'h0 :
    {carrier_detect_in, ring_indicator_in, data_set_ready_in, clear_to_send_in};
  assign modem_status = {modem_in, modem_delta_reg}; // [R10]

  assign data_ready = (fifo_level != '0); // [R15]
  assign global_err = fifo_on && (|fifo_head[10:8]) && data_ready;
  assign line_status = {global_err, tx_shifter_empty && (tx_state_reg == UCRM_TX_EMPTY),
    (tx_state_reg == UCRM_TX_EMPTY), fifo_head[10:8] & {3{data_ready}}, overrun_reg, data_ready}; // [R09]
  assign line_err = |line_status[4:1];

  assign src_line = interrupt_mask_reg[MASK_LINE_BIT] && line_err; // [R12]
  assign src_timeout = interrupt_mask_reg[MASK_RX_BIT] && fifo_on && rx_timeout && data_ready; // [R12]
  assign src_rx = interrupt_mask_reg[MASK_RX_BIT] && (fifo_on ? (fifo_level >= trigger) : data_ready); // [R13] [R14]
  assign src_tx = interrupt_mask_reg[MASK_TX_BIT] && tx_irq_reg; // [R12]
  assign src_modem = interrupt_mask_reg[MASK_MODEM_BIT] && (|modem_delta_reg); // [R12]

  always_comb begin
    if (src_line) begin
      src_code = SRC_LINE;
    end else if (src_timeout) begin
      src_code = SRC_TIMEOUT;
    end else if (src_rx) begin
      src_code = SRC_RX_DATA; // [R14]
    end else if (src_tx) begin
      src_code = SRC_TX_EMPTY;
    end else if (src_modem) begin
      src_code = SRC_MODEM;
    end else begin
      src_code = SRC_NONE; // [R18]
    end
  end

  assign interrupt_status = {{2{fifo_on}}, 2'b00, src_code}; // [R05] [R19]

  always_comb begin
    unique case (reg_addr)
      OFS_DATA: rd_data_reg = div_sel ? div_lo_reg : fifo_head[7:0]; // [R02] [R03]
      OFS_MASK: rd_data_reg = div_sel ? div_hi_reg : interrupt_mask_reg; // [R04]
      OFS_STATUS: rd_data_reg = interrupt_status; // [R05]
      OFS_FORMAT: rd_data_reg = line_format_reg; // [R07]
      OFS_MODEM_CTL: rd_data_reg = modem_control_reg; // [R08]
      OFS_LINE_STAT: rd_data_reg = line_status; // [R09]
      OFS_MODEM_STAT: rd_data_reg = modem_status; // [R10]
      OFS_SCRATCH: rd_data_reg = scratch_reg; // [R11]
    endcase
  end

  // Read data is registered: it appears the edge after the strobe and holds till the next read.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else if (clk_en && rd_hit) begin
      rd_data <= rd_data_reg;
    end
  end

  assign tx_char_valid = (tx_state_reg == UCRM_TX_HELD);
  assign tx_holding = tx_holding_reg;
  assign divisor = {div_hi_reg, div_lo_reg};
  assign line_format = line_format_reg;
  assign fifo_dma_mode = fifo_control_reg[FCR_DMA_BIT];
  assign loopback_en = modem_control_reg[MCTL_LOOP_BIT];
  assign irq_output_enable = modem_control_reg[MCTL_IRQ_EN_BIT];
  assign spare_output = modem_control_reg[MCTL_SPARE_BIT];
  assign rts_out = modem_control_reg[MCTL_RTS_BIT] && !loopback_en;
  assign dtr_out = modem_control_reg[MCTL_DTR_BIT] && !loopback_en;
  assign irq = irq_output_enable && !interrupt_status[0]; // [R14] [R18]
endmodule

// ===== hdl/ucrm_pkg.sv
// Package holding register offsets, field positions, reset values and codes of the serial channel.
package ucrm_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LEVEL_W = 5;
  localparam int unsigned PTR_W = 4;

  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_MASK = 3'h1;
  localparam logic [2:0] OFS_STATUS = 3'h2;
  localparam logic [2:0] OFS_FORMAT = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  localparam int unsigned FMT_DIV_BIT = 7;
  localparam int unsigned FMT_BREAK_BIT = 6;
  localparam int unsigned FCR_ENABLE_BIT = 0;
  localparam int unsigned FCR_RX_RESET_BIT = 1;
  localparam int unsigned FCR_TX_RESET_BIT = 2;
  localparam int unsigned FCR_DMA_BIT = 3;
  localparam int unsigned FCR_TRIG_LO = 6;
  localparam int unsigned MCTL_LOOP_BIT = 4;
  localparam int unsigned MCTL_IRQ_EN_BIT = 3;
  localparam int unsigned MCTL_RTS_BIT = 1;
  localparam int unsigned MCTL_DTR_BIT = 0;
  localparam int unsigned MCTL_SPARE_BIT = 2;
  localparam int unsigned MASK_RX_BIT = 0;
  localparam int unsigned MASK_TX_BIT = 1;
  localparam int unsigned MASK_LINE_BIT = 2;
  localparam int unsigned MASK_MODEM_BIT = 3;

  localparam logic [7:0] MASK_IMPL = 8'h0f;
  localparam logic [7:0] MCTL_IMPL = 8'h1f;
  localparam logic [7:0] FCR_IMPL = 8'hcf;
  localparam logic [7:0] FCR_KEEP = 8'hc9;

  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_FCR = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_MCTL = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hff;
  localparam logic [7:0] RST_DIV_LO = 8'h00;
  localparam logic [7:0] RST_DIV_HI = 8'h00;

  localparam logic [3:0] SRC_LINE = 4'h6;
  localparam logic [3:0] SRC_TIMEOUT = 4'hc;
  localparam logic [3:0] SRC_RX_DATA = 4'h4;
  localparam logic [3:0] SRC_TX_EMPTY = 4'h2;
  localparam logic [3:0] SRC_MODEM = 4'h0;
  localparam logic [3:0] SRC_NONE = 4'h1;

  localparam logic [LEVEL_W-1:0] TRIG_1 = 5'h01;
  localparam logic [LEVEL_W-1:0] TRIG_4 = 5'h04;
  localparam logic [LEVEL_W-1:0] TRIG_8 = 5'h08;
  localparam logic [LEVEL_W-1:0] TRIG_14 = 5'h0e;
endpackage

// ===== hdl/ucrm_rx_fifo.sv
// Receive FIFO of data bytes with three error tags per entry and a fill level.
module ucrm_rx_fifo
  import ucrm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic push,
  input wire logic [10:0] push_data,
  input wire logic pop,
  output logic [10:0] head_data,
  output logic [LEVEL_W-1:0] level,
  output logic full
);
  logic [10:0] mem_reg [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [LEVEL_W-1:0] level_reg;
  logic do_push;
  logic do_pop;

  assign full = (level_reg == LEVEL_W'(FIFO_DEPTH));
  assign do_push = push && !full;
  assign do_pop = pop && (level_reg != '0);
  assign level = level_reg;
  assign head_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge mclk) begin
    if (clk_en && do_push) begin
      mem_reg[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        level_reg <= '0;
      end else begin
        if (do_push) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (do_pop) begin
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
        if (do_push && !do_pop) begin
          level_reg <= level_reg + 1'b1;
        end else if (do_pop && !do_push) begin
          level_reg <= level_reg - 1'b1;
        end
      end
    end
  end
endmodule

// ===== verification/ucrm_properties.sv
// Concurrent checks of the channel's register bus effects at its ports.
module ucrm_properties
  import ucrm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic chan_sel,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic tx_char_valid,
  input wire logic [DATA_W-1:0] tx_holding,
  input wire logic tx_take,
  input wire logic [15:0] divisor,
  input wire logic [7:0] line_format,
  input wire logic fifo_dma_mode,
  input wire logic loopback_en,
  input wire logic irq_output_enable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic rd_go;
  logic wr_go;
  logic [DATA_W-1:0] wd_q;
  assign rd_go = clk_en && chan_sel && rd_strobe;
  assign wr_go = clk_en && chan_sel && wr_strobe;
  always_ff @(posedge mclk) begin
    wd_q <= wr_data;
  end
  a_mask_upper: assert property (rd_go && reg_addr == OFS_MASK && !line_format[7] |=> rd_data[7:4] == 4'h0)
    else $error("mask upper bits not zero");
  a_status_bits: assert property (rd_go && reg_addr == OFS_STATUS |=> rd_data[5:4] == 2'h0 && rd_data[7] == rd_data[6])
    else $error("status fixed bits wrong");
  a_mctl_upper: assert property (rd_go && reg_addr == OFS_MODEM_CTL |=> rd_data[7:5] == 3'h0)
    else $error("modem control upper bits not zero");
  a_div_low: assert property (wr_go && reg_addr == OFS_DATA && line_format[7] |=> divisor[7:0] == wd_q)
    else $error("divisor low byte not loaded");
  a_format_load: assert property (wr_go && reg_addr == OFS_FORMAT |=> line_format == wd_q)
    else $error("line format not loaded");
  a_tx_load: assert property (wr_go && reg_addr == OFS_DATA && !line_format[7] && !tx_take |=> tx_char_valid && tx_holding == wd_q)
    else $error("transmit byte not loaded");
  a_mctl_load: assert property (wr_go && reg_addr == OFS_MODEM_CTL |=> loopback_en == wd_q[4] && irq_output_enable == wd_q[3])
    else $error("modem control bits not loaded");
  a_fcr_gate: assert property (wr_go && reg_addr == OFS_STATUS |=> fifo_dma_mode == (wd_q[0] && wd_q[3]))
    else $error("dma mode not gated by enable");
  a_chan_ignore: assert property (wr_strobe && !chan_sel |=> $stable(line_format) && $stable(divisor))
    else $error("unselected write changed state");
  c_irq: cover property (irq);
  c_fifo_on: cover property (wr_go && reg_addr == OFS_STATUS && wr_data[0]);
  c_tx_taken: cover property (tx_char_valid ##1 !tx_char_valid);
endmodule

// ===== verification/ucrm_host_model.sv
// Host processor model driving the channel's parallel register bus.
module ucrm_host_model
  import ucrm_pkg::*;
(
  input wire logic mclk,
  input wire logic [DATA_W-1:0] rd_data,
  output logic chan_sel,
  output logic [ADDR_W-1:0] reg_addr,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [DATA_W-1:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Between accesses the bus is released and shows the inverse of its last values.
  task automatic idle();
    chan_sel = 1'b0;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    reg_addr = ~reg_addr;
    wr_data = ~wr_data;
  endtask
  initial begin
    reg_addr = 3'h0;
    wr_data = 8'h00;
    idle();
  end
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic sel, output logic [7:0] q);
    @(posedge mclk);
    #2;
    chan_sel = sel;
    reg_addr = a;
    wr_data = d;
    rd_strobe = !w;
    wr_strobe = w;
    @(posedge mclk);
    #2;
    q = rd_data;
    idle();
  endtask
endmodule

// ===== verification/uart_channel_register_map_test.sv
// Self-checking bench of one serial channel's register set.
module uart_channel_register_map_test
  import ucrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] r;} ucrm_row_type;
  logic mclk = 1'b0;
  logic rst_b, chan_sel, rd_strobe, wr_strobe, rx_char_valid, tx_char_valid, tx_take, tx_shifter_empty;
  logic clear_to_send_in, data_set_ready_in, ring_indicator_in, carrier_detect_in, fifo_dma_mode, irq;
  logic clk_en, rx_parity_err, rx_framing_err, rx_break, rx_timeout, spare_output, rts_out, dtr_out;
  logic [15:0] divisor;
  logic [2:0] reg_addr;
  logic [7:0] wr_data, rd_data, rx_char, tx_holding, q;
  logic [4:0] trig [4] = '{5'h1, 5'h4, 5'h8, 5'he};
  int err_total = 0;
  int checked = 0;
  ucrm_row_type rows [11] = '{
    '{3'h3, 8'h1b, 8'h1b}, '{3'h1, 8'hff, 8'h0f}, '{3'h1, 8'h00, 8'h00},
    '{3'h4, 8'hff, 8'h1f}, '{3'h4, 8'h00, 8'h00}, '{3'h7, 8'ha5, 8'ha5},
    '{3'h6, 8'hff, 8'h00}, '{3'h2, 8'h30, 8'h01}, '{3'h3, 8'h80, 8'h80},
    '{3'h0, 8'h34, 8'h34}, '{3'h1, 8'h12, 8'h12}};
  ucrm_channel u_dut (.mclk, .rst_b, .clk_en, .chan_sel, .reg_addr, .rd_strobe, .wr_strobe, .wr_data,
    .rd_data, .rx_char_valid, .rx_char, .rx_parity_err, .rx_framing_err, .rx_break,
    .rx_timeout, .tx_char_valid, .tx_holding, .tx_take, .tx_shifter_empty, .clear_to_send_in,
    .data_set_ready_in, .ring_indicator_in, .carrier_detect_in, .divisor, .line_format(), .fifo_dma_mode,
    .loopback_en(), .irq_output_enable(), .spare_output, .rts_out, .dtr_out, .irq);
  ucrm_host_model u_host (.mclk, .rd_data, .chan_sel, .reg_addr, .rd_strobe, .wr_strobe, .wr_data);
  always #25 mclk = ~mclk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    u_host.acc(1'b0, a, 8'h00, 1'b1, q);
    chk(q, e, m);
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge mclk);
    #2;
    rx_char_valid = 1'b1;
    rx_char = d;
    @(posedge mclk);
    #2;
    rx_char_valid = 1'b0;
    rx_char = ~d;
  endtask
  task automatic summarize();
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    {rx_char_valid, tx_take, clear_to_send_in, data_set_ready_in, ring_indicator_in, carrier_detect_in} = 6'h00;
    {clk_en, rx_parity_err, rx_framing_err, rx_break, rx_timeout} = 5'h10;
    rx_char = 8'h00;
    tx_shifter_empty = 1'b1;
    repeat (12) @(posedge mclk);
    #2;
    rst_b = 1'b1;
    rd(OFS_STATUS, 8'h01, 8'hff);
    rd(OFS_SCRATCH, 8'hff, 8'hff);
    rd(OFS_LINE_STAT, 8'h60, 8'hff);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r, 8'hff);
    end
    chk(divisor[15:8], 8'h12, 8'hff);
    chk(divisor[7:0], 8'h34, 8'hff);
    wr(OFS_FORMAT, 8'h03);
    u_host.acc(1'b1, OFS_SCRATCH, 8'h00, 1'b0, q);
    rd(OFS_SCRATCH, 8'ha5, 8'hff);
    wr(OFS_MODEM_CTL, 8'h13);
    chk({5'h00, spare_output, rts_out, dtr_out}, 8'h00, 8'hff);
    wr(OFS_MODEM_CTL, 8'h07);
    chk({5'h00, spare_output, rts_out, dtr_out}, 8'h07, 8'hff);
    clear_to_send_in = 1'b1;
    repeat (3) @(posedge mclk);
    rd(OFS_MODEM_STAT, 8'h11, 8'hff);
    rd(OFS_MODEM_STAT, 8'h10, 8'hff);
    tx_shifter_empty = 1'b0;
    wr(OFS_DATA, 8'h5c);
    chk({7'h00, tx_char_valid}, 8'h01, 8'hff);
    chk(tx_holding, 8'h5c, 8'hff);
    rd(OFS_LINE_STAT, 8'h00, 8'h60);
    tx_take = 1'b1;
    @(posedge mclk);
    #2;
    tx_take = 1'b0;
    tx_shifter_empty = 1'b1;
    chk({7'h00, tx_char_valid}, 8'h00, 8'hff);
    wr(OFS_MODEM_CTL, 8'h08);
    wr(OFS_MASK, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_STATUS, {c[1:0], 6'h03});
      for (int k = 1; k < trig[c]; k++) begin
        push(k[7:0]);
      end
      rd(OFS_STATUS, 8'hc1, 8'hff);
      push(8'h5a);
      rd(OFS_STATUS, 8'hc4, 8'hff);
      chk({7'h00, irq}, 8'h01, 8'hff);
      wr(OFS_MASK, 8'h00);
      rd(OFS_STATUS, 8'hc1, 8'hff);
      wr(OFS_MASK, 8'h01);
      rd(OFS_LINE_STAT, 8'h01, 8'h01);
      rd(OFS_DATA, (c == 0) ? 8'h5a : 8'h01, 8'hff);
      rd(OFS_STATUS, 8'hc1, 8'hff);
      chk({7'h00, irq}, 8'h00, 8'hff);
    end
    wr(OFS_STATUS, 8'h0b);
    chk({7'h00, fifo_dma_mode}, 8'h01, 8'hff);
    rd(OFS_STATUS, 8'hc1, 8'hff);
    wr(OFS_STATUS, 8'h08);
    chk({7'h00, fifo_dma_mode}, 8'h00, 8'hff);
    rd(OFS_STATUS, 8'h01, 8'hff);
    push(8'h7e);
    rd(OFS_LINE_STAT, 8'h01, 8'h01);
    rd(OFS_DATA, 8'h7e, 8'hff);
    rd(OFS_LINE_STAT, 8'h00, 8'h01);
    wr(OFS_STATUS, 8'h01);
    wr(OFS_MASK, 8'h05);
    rx_parity_err = 1'b1;
    push(8'h3c);
    rx_parity_err = 1'b0;
    rd(OFS_STATUS, 8'hc6, 8'hff);
    rd(OFS_LINE_STAT, 8'he5, 8'hff);
    rd(OFS_DATA, 8'h3c, 8'hff);
    rx_timeout = 1'b1;
    push(8'h44);
    rd(OFS_STATUS, 8'hcc, 8'hff);
    rx_timeout = 1'b0;
    rd(OFS_DATA, 8'h44, 8'hff);
    wr(OFS_STATUS, 8'h00);
    push(8'h11);
    push(8'h22);
    rd(OFS_STATUS, 8'h06, 8'hff);
    rd(OFS_LINE_STAT, 8'h63, 8'hff);
    rd(OFS_LINE_STAT, 8'h61, 8'hff);
    rd(OFS_DATA, 8'h11, 8'hff);
    clk_en = 1'b0;
    wr(OFS_SCRATCH, 8'h3c);
    clk_en = 1'b1;
    rd(OFS_SCRATCH, 8'ha5, 8'hff);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end
endmodule
bind ucrm_channel ucrm_properties u_props (.mclk, .rst_b, .clk_en, .chan_sel, .reg_addr, .rd_strobe, .wr_strobe,
  .wr_data, .rd_data, .tx_char_valid, .tx_holding, .tx_take, .divisor, .line_format, .fifo_dma_mode,
  .loopback_en, .irq_output_enable, .irq);
